// >>> rtl/pmc_top.sv
// power mode controller: apb registers, mode sequencing and power gating
//
// Summary of operation
// - Four modes ranked by consumption: active, alternate active, sleep, hibernate.
// - In active and alternate active each subsystem follows its template bit.
// - Sleep disables subsystems regardless of templates; only low-speed clocks run.
// - Hibernate stops all clocks, keeps state, and wakes only from pin events.
// - Active entered by wakeup, reset or write; enabled interrupts wake.
// - Alternate active entered only by write; own template, cpu may be off.
// - Sleep wakes on six event sources; resets on pin, low voltage, watchdog.
// - Hibernate: only hibernate regulator on; port interrupt wakes, reset pin resets.
// - Wakeup completes within 15 us from sleep and 100 us from hibernate.
`timescale 1ns/100ps
module pmc_top
	import pmc_pkg::*;
#(
	parameter int N = 8,
	parameter logic [CNT_W-1:0] SLEEP_SETTLE_CYC = 12'h010,
	parameter logic [CNT_W-1:0] HIB_SETTLE_CYC = 12'h040
) (
	input wire logic I_CLK, // 40 MHz system clock
	input wire logic I_RST_N, // synchronous reset, active low
	input wire logic I_PSEL, // apb select
	input wire logic I_PENABLE, // apb enable
	input wire logic I_PWRITE, // apb direction
	input wire logic [ADDR_W-1:0] I_PADDR, // apb byte address
	input wire logic [31:0] I_PWDATA, // apb write data
	output logic [31:0] O_PRDATA, // apb read data
	output logic O_PREADY, // apb ready
	output logic O_PSLVERR, // apb error on unmapped address
	input wire pmc_wake_t I_WAKE, // asynchronous wake events
	input wire pmc_rst_src_t I_RST_SRC, // asynchronous reset sources
	input wire logic I_IRQ, // pending interrupt, same clock
	output pmc_mode_t O_MODE, // current mode code
	output logic [N-1:0] O_SUBSYS_EN, // subsystem enables
	output pmc_pwr_t O_PWR, // clock, regulator and cpu enables
	output logic O_RESET_REQ // system reset request
);

	typedef struct packed {
		pmc_state_t state;
		logic [CNT_W-1:0] cnt;
		logic hib_wake;
		logic [N-1:0] act_tpl;
		logic [N-1:0] alt_tpl;
		logic alt_cpu;
		logic irq_en;
		logic [CAUSE_W-1:0] cause;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		pmc_mode_t mode;
		logic [N-1:0] subsys;
		pmc_pwr_t pwr;
		logic reset_req;
	} pmc_top_st_t;

	pmc_top_st_t r_reg;
	pmc_top_st_t r_next;
	logic [WAKE_W+RST_W-1:0] syn_bits;
	pmc_wake_t syn_wake;
	pmc_rst_src_t syn_rst;
	logic wr_go;
	logic wr_mode;
	logic irq_wake;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	pmc_sync #(
		.W(WAKE_W + RST_W)
	) u_sync (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_async({I_RST_SRC, I_WAKE}),
		.o_sync(syn_bits)
	);

	assign syn_wake = pmc_wake_t'(syn_bits[WAKE_W-1:0]);
	assign syn_rst = pmc_rst_src_t'(syn_bits[WAKE_W+RST_W-1:WAKE_W]);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a == REG_CTRL) || (a == REG_ACT_TPL) || (a == REG_ALT_TPL) ||
			(a == REG_IRQ_EN) || (a == REG_STATUS);
	endfunction

	function automatic pmc_state_t mode_state(input logic [1:0] code);
		case (code)
			MODE_ALT: mode_state = ST_ALT;
			MODE_SLEEP: mode_state = ST_SLEEP;
			MODE_HIB: mode_state = ST_HIB;
			default: mode_state = ST_ACTIVE;
		endcase
	endfunction

	// write takes effect on the edge where the master sees pready
	assign wr_go = I_PSEL && I_PENABLE && r_reg.pready && I_PWRITE;
	// mode requests only count while software is running
	assign wr_mode = wr_go && (I_PADDR == REG_CTRL) &&
		(r_reg.state == ST_ACTIVE || r_reg.state == ST_ALT);
	assign irq_wake = I_IRQ && r_reg.irq_en;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [CAUSE_W-1:0] set_cause;
		logic [CAUSE_W-1:0] clr_cause;
		set_cause = '0;
		clr_cause = '0;
		r_next = r_reg;

		// apb: one wait state, data and error loaded with ready
		r_next.pready = I_PSEL && I_PENABLE && !r_reg.pready;
		if (r_next.pready) begin
			r_next.pslverr = !addr_hit(I_PADDR);
			r_next.prdata = '0;
			case (I_PADDR)
				REG_CTRL: begin
					r_next.prdata[CTRL_MODE_LSB +: 2] = r_reg.mode;
					r_next.prdata[CTRL_ALT_CPU_BIT] = r_reg.alt_cpu;
				end
				REG_ACT_TPL: r_next.prdata[N-1:0] = r_reg.act_tpl;
				REG_ALT_TPL: r_next.prdata[N-1:0] = r_reg.alt_tpl;
				REG_IRQ_EN: r_next.prdata[IRQ_EN_BIT] = r_reg.irq_en;
				REG_STATUS: begin
					r_next.prdata[STATUS_MODE_LSB +: 2] = r_reg.mode;
					r_next.prdata[STATUS_WAKING_BIT] = (r_reg.state == ST_WAKE);
					r_next.prdata[STATUS_CAUSE_LSB +: CAUSE_W] = r_reg.cause;
				end
				default: r_next.prdata = '0;
			endcase
		end

		if (wr_go) begin
			case (I_PADDR)
				REG_CTRL: r_next.alt_cpu = I_PWDATA[CTRL_ALT_CPU_BIT];
				REG_ACT_TPL: r_next.act_tpl = I_PWDATA[N-1:0];
				REG_ALT_TPL: r_next.alt_tpl = I_PWDATA[N-1:0];
				REG_IRQ_EN: r_next.irq_en = I_PWDATA[IRQ_EN_BIT];
				REG_STATUS: clr_cause = I_PWDATA[STATUS_CAUSE_LSB +: CAUSE_W];
				default: clr_cause = '0;
			endcase
		end

		// mode sequencer
		case (r_reg.state)
			ST_ACTIVE: begin
				if (wr_mode) begin
					r_next.state = mode_state(I_PWDATA[CTRL_MODE_LSB +: 2]);
				end
			end
			ST_ALT: begin
				if (irq_wake) begin
					r_next.state = ST_ACTIVE;
					set_cause[CAUSE_IRQ_BIT] = 1'b1;
				end else if (wr_mode) begin
					r_next.state = mode_state(I_PWDATA[CTRL_MODE_LSB +: 2]);
				end
			end
			ST_SLEEP: begin
				if (|syn_wake) begin
					r_next.state = ST_WAKE;
					r_next.cnt = SLEEP_SETTLE_CYC;
					r_next.hib_wake = 1'b0;
					set_cause[WAKE_W-1:0] = syn_wake;
				end
			end
			ST_HIB: begin
				// pin events only: no clocked source is alive here
				if (syn_wake.port_interrupt_unit) begin
					r_next.state = ST_WAKE;
					r_next.cnt = HIB_SETTLE_CYC;
					r_next.hib_wake = 1'b1;
					set_cause[WAKE_W-1:0] = syn_wake & pmc_wake_t'(6'h10);
				end
			end
			ST_WAKE: begin
				if (r_reg.cnt == '0) begin
					r_next.state = ST_ACTIVE;
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			default: r_next.state = ST_ACTIVE;
		endcase

		// a new event wins over a clear in the same cycle
		r_next.cause = (r_reg.cause & ~clr_cause) | set_cause;

		// reset sources per mode
		r_next.reset_req = syn_rst.external_reset_pin || (r_reg.state != ST_HIB &&
			(syn_rst.low_voltage_detect || syn_rst.watchdog_reset));

		// outputs follow the next state so they line up with it
		r_next.pwr = '0;
		r_next.pwr.hib_reg_en = 1'b1;
		r_next.subsys = '0;
		case (r_next.state)
			ST_ALT: begin
				r_next.mode = MODE_ALT;
				r_next.subsys = r_next.alt_tpl;
				r_next.pwr.cpu_en = r_next.alt_cpu;
				r_next.pwr.hs_clk_en = 1'b1;
				r_next.pwr.ls_clk_en = 1'b1;
				r_next.pwr.main_reg_en = 1'b1;
			end
			ST_SLEEP: begin
				r_next.mode = MODE_SLEEP;
				r_next.pwr.ls_clk_en = 1'b1;
				r_next.pwr.main_reg_en = 1'b1;
				r_next.pwr.reg_buzz = 1'b1;
			end
			ST_HIB: r_next.mode = MODE_HIB;
			ST_WAKE: begin
				// regulators and clocks settle before the cpu restarts
				r_next.mode = MODE_ACTIVE;
				r_next.pwr.hs_clk_en = 1'b1;
				r_next.pwr.ls_clk_en = 1'b1;
				r_next.pwr.main_reg_en = 1'b1;
			end
			default: begin
				r_next.mode = MODE_ACTIVE;
				r_next.subsys = r_next.act_tpl;
				r_next.pwr.cpu_en = 1'b1;
				r_next.pwr.hs_clk_en = 1'b1;
				r_next.pwr.ls_clk_en = 1'b1;
				r_next.pwr.main_reg_en = 1'b1;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			r_reg <= '0;
			r_reg.state <= ST_ACTIVE;
			r_reg.act_tpl <= '1;
			r_reg.alt_cpu <= ALT_CPU_RST;
			r_reg.irq_en <= IRQ_EN_RST;
			r_reg.mode <= MODE_ACTIVE;
			r_reg.subsys <= '1;
			r_reg.pwr <= '1;
			r_reg.pwr.reg_buzz <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign O_PRDATA = r_reg.prdata;
	assign O_PREADY = r_reg.pready;
	assign O_PSLVERR = r_reg.pslverr;
	assign O_MODE = r_reg.mode;
	assign O_SUBSYS_EN = r_reg.subsys;
	assign O_PWR = r_reg.pwr;
	assign O_RESET_REQ = r_reg.reset_req;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);

	localparam int SLP_LIM = SLEEP_WAKE_MAX_CYC - SYNC_LAT_CYC;
	localparam int HIB_LIM = HIB_WAKE_MAX_CYC - SYNC_LAT_CYC;

	a_mode_code: assert property ((r_reg.state == ST_HIB) == (O_MODE == MODE_HIB))
		else $error("mode code disagrees with hibernate state");
	a_active_template: assert property (r_reg.state == ST_ACTIVE |-> O_SUBSYS_EN == r_reg.act_tpl)
		else $error("active enables differ from template");
	a_sleep_gating: assert property (r_reg.state == ST_SLEEP |->
		O_SUBSYS_EN == '0 && !O_PWR.hs_clk_en && O_PWR.ls_clk_en && !O_PWR.cpu_en)
		else $error("sleep gating wrong");
	a_hib_all_off: assert property (r_reg.state == ST_HIB |->
		O_PWR == pmc_pwr_t'(6'h02) && O_SUBSYS_EN == '0)
		else $error("hibernate left something on");
	a_alt_irq_wake: assert property (r_reg.state == ST_ALT && irq_wake |=>
		r_reg.state == ST_ACTIVE && r_reg.cause[CAUSE_IRQ_BIT])
		else $error("interrupt did not wake alternate mode");
	a_alt_entry_write: assert property ($rose(r_reg.state == ST_ALT) |->
		$past(wr_mode) && O_SUBSYS_EN == r_reg.alt_tpl && O_PWR.cpu_en == r_reg.alt_cpu)
		else $error("alternate mode entered without write");
	a_sleep_reset: assert property (r_reg.state == ST_SLEEP && syn_rst.watchdog_reset |=>
		O_RESET_REQ)
		else $error("watchdog reset lost in sleep");
	a_hib_wake_src: assert property (r_reg.state == ST_HIB && !syn_wake.port_interrupt_unit
		|=> r_reg.state == ST_HIB && (O_RESET_REQ == $past(syn_rst.external_reset_pin)))
		else $error("hibernate left or reset by wrong source");
	a_sleep_wake_time: assert property (r_reg.state == ST_WAKE && !r_reg.hib_wake |->
		r_reg.cnt < SLP_LIM)
		else $error("sleep wakeup too long");
	a_hib_wake_time: assert property (r_reg.state == ST_WAKE && r_reg.hib_wake |->
		r_reg.cnt < HIB_LIM)
		else $error("hibernate wakeup too long");
	a_wake_to_active: assert property (r_reg.state == ST_WAKE && r_reg.cnt == '0 |=>
		r_reg.state == ST_ACTIVE && O_SUBSYS_EN == r_reg.act_tpl && O_PWR.cpu_en)
		else $error("wake did not restore active mode");

endmodule

// >>> rtl/pmc_pkg.sv
// power mode controller: shared constants, codes and carrier types
package pmc_pkg;

	// ----------------------------------------
	// clock and wakeup timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int SLEEP_WAKE_MAX_NS = 15000;
	localparam int HIB_WAKE_MAX_NS = 100000;
	// longest times round down to whole cycles
	localparam int SLEEP_WAKE_MAX_CYC = SLEEP_WAKE_MAX_NS * CLK_MHZ / 1000;
	localparam int HIB_WAKE_MAX_CYC = HIB_WAKE_MAX_NS * CLK_MHZ / 1000;
	localparam int CNT_W = 12;
	localparam int SYNC_LAT_CYC = 3;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_ACT_TPL = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ALT_TPL = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_ALT_CPU_BIT = 2;
	localparam int IRQ_EN_BIT = 0;
	localparam int STATUS_MODE_LSB = 0;
	localparam int STATUS_WAKING_BIT = 2;
	localparam int STATUS_CAUSE_LSB = 8;

	localparam logic ALT_CPU_RST = 1'b0;
	localparam logic IRQ_EN_RST = 1'b1;

	// ----------------------------------------
	// modes, states and carriers
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_ACTIVE = 2'h0,
		MODE_ALT = 2'h1,
		MODE_SLEEP = 2'h2,
		MODE_HIB = 2'h3
	} pmc_mode_t;

	typedef enum logic [4:0] {
		ST_ACTIVE = 5'h01,
		ST_ALT = 5'h02,
		ST_SLEEP = 5'h04,
		ST_HIB = 5'h08,
		ST_WAKE = 5'h10
	} pmc_state_t;

	localparam int WAKE_W = 6;
	localparam int RST_W = 3;
	localparam int CAUSE_W = WAKE_W + 1;
	localparam int CAUSE_IRQ_BIT = WAKE_W;

	typedef struct packed {
		logic comparator;
		logic port_interrupt_unit;
		logic i2c;
		logic rtc;
		logic central_timewheel;
		logic low_voltage_detect;
	} pmc_wake_t;

	typedef struct packed {
		logic external_reset_pin;
		logic low_voltage_detect;
		logic watchdog_reset;
	} pmc_rst_src_t;

	typedef struct packed {
		logic hs_clk_en;
		logic ls_clk_en;
		logic main_reg_en;
		logic reg_buzz;
		logic hib_reg_en;
		logic cpu_en;
	} pmc_pwr_t;

endpackage

// >>> rtl/pmc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pmc_sync
	import pmc_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic i_clk, // system clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic [W-1:0] i_async, // inputs from outside the domain
	output logic [W-1:0] o_sync // filtered levels
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} pmc_sync_st_t;

	pmc_sync_st_t r_reg;
	pmc_sync_st_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.s1 = i_async;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		// a change counts only once stages two and three agree
		r_next.q = (~(r_reg.s2 ^ r_reg.s3) & r_reg.s3) | ((r_reg.s2 ^ r_reg.s3) & r_reg.q);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_sync = r_reg.q;

endmodule

// >>> test/pmc_wake_src.sv
// wake and reset source model with programmable response delay
`timescale 1ns/100ps
module pmc_wake_src
	import pmc_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_go, // load new levels
	input wire logic [7:0] i_dly, // cycles before the new levels show
	input wire pmc_wake_t i_wake, // wake levels to present
	input wire pmc_rst_src_t i_rst, // reset levels to present
	output pmc_wake_t o_wake, // wake events to the controller
	output pmc_rst_src_t o_rst // reset sources to the controller
);
	logic [7:0] cnt_reg = 8'h00;
	pmc_wake_t wake_reg = '0;
	pmc_rst_src_t rst_reg = '0;
	// one process drives the shown levels, quiet from time zero
	pmc_wake_t wake_out_reg = '0;
	pmc_rst_src_t rst_out_reg = '0;

	// levels hold until replaced; a slow source only waits longer
	always @(posedge i_clk) begin
		if (i_go) begin
			cnt_reg <= i_dly;
			wake_reg <= i_wake;
			rst_reg <= i_rst;
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end else begin
			wake_out_reg <= wake_reg;
			rst_out_reg <= rst_reg;
		end
	end

	assign o_wake = wake_out_reg;
	assign o_rst = rst_out_reg;
endmodule

// >>> test/pmc_top_tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
module pmc_top_tb;
	import pmc_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq = 1'b0;
	logic go = 1'b0;
	logic [7:0] dly = 8'h00;
	pmc_wake_t wk_in = '0;
	pmc_rst_src_t rs_in = '0;
	pmc_wake_t wake;
	pmc_rst_src_t rst_src;
	pmc_mode_t mode;
	logic [7:0] subsys;
	pmc_pwr_t pwr;
	logic reset_req;
	logic [31:0] d;
	logic e;
	int fails = 0;
	int total_checks = 0;

	always #12.5 clk = ~clk;

	// short settle counts keep the run brief
	pmc_top #(.N(8), .SLEEP_SETTLE_CYC(12'h002), .HIB_SETTLE_CYC(12'h004)) i_pmc_top (
		.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_WAKE(wake), .I_RST_SRC(rst_src),
		.I_IRQ(irq), .O_MODE(mode), .O_SUBSYS_EN(subsys), .O_PWR(pwr),
		.O_RESET_REQ(reset_req)
	);

	pmc_wake_src i_pmc_wake_src (
		.i_clk(clk), .i_go(go), .i_dly(dly), .i_wake(wk_in), .i_rst(rs_in),
		.o_wake(wake), .o_rst(rst_src)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		if (fails == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			chk(32'(n), 32'h0);
			tally_and_finish();
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(d, exp);
	endtask

	task automatic wake_go(input logic [5:0] w, input logic [2:0] r, input logic [7:0] t);
		go <= 1'b1;
		wk_in <= w;
		rs_in <= r;
		dly <= t;
		@(posedge clk);
		go <= 1'b0;
	endtask

	// wait for active with the cpu running, inside the allowed time
	task automatic wait_active(input int lim);
		int n;
		n = 0;
		while (!(mode === MODE_ACTIVE && pwr.cpu_en === 1'b1) && n <= lim) begin
			@(posedge clk);
			n++;
		end
		if (n > lim) begin
			chk(32'(n), 32'(lim));
			tally_and_finish();
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tick(5);
		rst_n <= 1'b1;
		chk(mode, MODE_ACTIVE);
		chk(pwr, 32'h3B);
		chk(subsys, 32'hFF);
		rd_chk(REG_ACT_TPL, 32'hFF);
		rd_chk(REG_ALT_TPL, 32'h0);
		rd_chk(REG_IRQ_EN, 32'h1);
		rd_chk(REG_STATUS, 32'h0);
		rd_chk(8'h14, 32'h0);
		chk(e, 32'h1);
		apb(1'b1, REG_ALT_TPL, 32'h5A);
		apb(1'b1, REG_IRQ_EN, 32'h0);
		apb(1'b1, REG_CTRL, 32'h1);
		tick(2);
		chk(mode, MODE_ALT);
		chk(subsys, 32'h5A);
		chk(pwr.cpu_en, 32'h0);
		irq <= 1'b1;
		tick(6);
		chk(mode, MODE_ALT);
		apb(1'b1, REG_IRQ_EN, 32'h1);
		wait_active(10);
		chk(subsys, 32'hFF);
		irq <= 1'b0;
		rd_chk(REG_STATUS, 32'h4000);
		apb(1'b1, REG_STATUS, 32'h4000);
		apb(1'b1, REG_ACT_TPL, 32'h3C);
		tick(2);
		chk(subsys, 32'h3C);
		for (int i = 0; i < WAKE_W; i++) begin
			apb(1'b1, REG_CTRL, 32'h2);
			tick(2);
			chk(mode, MODE_SLEEP);
			chk(subsys, 32'h0);
			chk({pwr.hs_clk_en, pwr.ls_clk_en, pwr.reg_buzz, pwr.cpu_en}, 32'h6);
			wake_go(6'(1 << i), 3'h0, 8'(i * 8));
			wait_active(SLEEP_WAKE_MAX_CYC + i * 8);
			chk(subsys, 32'h3C);
			rd_chk(REG_STATUS, 32'(1 << (8 + i)));
			apb(1'b1, REG_STATUS, 32'(1 << (8 + i)));
			wake_go(6'h0, 3'h0, 8'h0);
			tick(8);
		end
		apb(1'b1, REG_CTRL, 32'h2);
		tick(2);
		wake_go(6'h0, 3'h1, 8'h0);
		tick(8);
		chk(reset_req, 32'h1);
		wake_go(6'h0, 3'h0, 8'h0);
		tick(8);
		chk(reset_req, 32'h0);
		wake_go(6'h20, 3'h0, 8'h0);
		wait_active(SLEEP_WAKE_MAX_CYC);
		wake_go(6'h0, 3'h0, 8'h0);
		tick(8);
		apb(1'b1, REG_CTRL, 32'h3);
		tick(2);
		chk(mode, MODE_HIB);
		chk(pwr, 32'h02);
		// every source but the port interrupt, and the two lesser resets
		wake_go(6'h2F, 3'h3, 8'h0);
		tick(10);
		chk(mode, MODE_HIB);
		chk(reset_req, 32'h0);
		wake_go(6'h2F, 3'h7, 8'h0);
		tick(8);
		chk(reset_req, 32'h1);
		wake_go(6'h10, 3'h0, 8'd40);
		wait_active(HIB_WAKE_MAX_CYC + 40);
		chk(subsys, 32'h3C);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(d & 32'h1000, 32'h1000);
		// alternate mode with the cpu kept on, then a reset in mid-run
		apb(1'b1, REG_CTRL, 32'h5);
		tick(2);
		chk(mode, MODE_ALT);
		chk(pwr.cpu_en, 32'h1);
		rd_chk(REG_CTRL, 32'h5);
		rst_n <= 1'b0;
		tick(4);
		rst_n <= 1'b1;
		chk(mode, MODE_ACTIVE);
		chk(pwr, 32'h3B);
		chk(subsys, 32'hFF);
		rd_chk(REG_STATUS, 32'h0);
		rd_chk(REG_CTRL, 32'h0);
		tally_and_finish();
	end
endmodule
